// file: hw/hlt_defs.vh
`ifndef HLT_DEFS_VH
`define HLT_DEFS_VH
// register byte offsets
`define HLT_OFF_CTRL        12'h000
`define HLT_OFF_PERIOD      12'h004
`define HLT_OFF_COUNT       12'h008
`define HLT_OFF_STATUS      12'h00c
// control register fields
`define HLT_CTRL_MODE_LO    0
`define HLT_CTRL_MODE_HI    4
`define HLT_CTRL_ON         7
`define HLT_CTRL_INST       8
// status register fields
`define HLT_STAT_ARMED      0
`define HLT_STAT_EXT        1
`define HLT_STAT_ON_EFF     2
// mode groups, upper mode bits
`define HLT_GRP_FREE        2'h0
`define HLT_GRP_ONESHOT     2'h1
`define HLT_GRP_MONO        2'h2
// lower mode bits
`define HLT_LO_SOFT         3'h0
`define HLT_LO_RISE         3'h1
`define HLT_LO_FALL         3'h2
`define HLT_LO_ANY          3'h3
`define HLT_LO_RISE_RST     3'h4
`define HLT_LO_FALL_RST     3'h5
`define HLT_LO_RISE_LOWRST  3'h6
`define HLT_LO_FALL_HIGHRST 3'h7
// reset values
`define HLT_RST_MODE        5'h00
`define HLT_RST_PERIOD      8'hff
`define HLT_RST_COUNT       8'h00
// clock rates in MHz; the timer derives its divider defaults from them
`define HLT_PCLK_MHZ        40
`define HLT_TMR_MHZ         10
`define HLT_INST_MHZ        10
`endif

// file: hw/hlt_timer.v
`timescale 1ns/100ps
`include "hlt_defs.vh"

//////////////////////////////////////////////////////////////////////////////
// Contract
// - software gate mode counts each selected tick, timer or instruction, while enabled, holds while disabled.
// - software gate mode wraps from period match to zero and keeps counting.
// - edge start modes need a fresh edge after enable is set again.
// - one-shot group: tick after period match clears enable, counter stops at zero; software code on timer clock stops at one.
// - monostable group: tick after period match stops counter at zero, enable stays.
// - on timer clock, enable and external input synchronise over two timer ticks.
// - on instruction clock, external input takes effect after one instruction period.
// - on instruction clock, enable change acts in the next instruction period.
// - external input ignored while processor is halted in debug.
module hlt_timer #(
  parameter TMR_DIV  = `HLT_PCLK_MHZ / `HLT_TMR_MHZ,
  parameter INST_DIV = `HLT_PCLK_MHZ / `HLT_INST_MHZ
) (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // external reset/trigger and debug halt
  input  wire        ext_reset_trigger_in,
  input  wire        debug_halt,
  // timer state
  output reg  [7:0]  count_value,
  output reg         period_match,
  output reg         timer_on
);

  //////////////////////////////////////////////////////////////////////////////
  // declarations
  reg  [7:0]  tdiv_reg;
  reg  [7:0]  idiv_reg;
  reg         tmr_tick;
  reg         inst_tick;
  reg  [4:0]  mode_reg;
  reg         inst_sel_reg;
  reg  [7:0]  period_value;
  reg         ext_q1;
  reg         ext_q2;
  reg         ext_q3;
  reg         ext_stable;
  reg         ext_s1;
  reg         ext_s2;
  reg         ext_prev;
  reg         on_s1;
  reg         on_s2;
  reg         armed_reg;
  reg         need_rst_reg;
  reg         armed_next;
  reg         need_rst_next;
  reg  [7:0]  count_next;
  reg         hw_clear_on;
  reg         match_next;
  wire        tick;
  wire        ext_eff;
  wire        on_eff;
  wire [1:0]  grp;
  wire [2:0]  lo;
  wire        ext_rise;
  wire        ext_fall;
  wire        start_edge;
  wire        is_match;
  wire        apb_setup;
  wire        apb_write;
  wire [31:0] rd_word;
  wire        rd_hit;

  // address decode used by the error flag only; the read mux compares the offsets itself
  function addr_mapped;
    input [11:0] a;
    begin
      addr_mapped = (a == `HLT_OFF_CTRL) || (a == `HLT_OFF_PERIOD) ||
                    (a == `HLT_OFF_COUNT) || (a == `HLT_OFF_STATUS);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // tick dividers: one-cycle enables, no second clock domain
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tdiv_reg  <= 8'h00;
      idiv_reg  <= 8'h00;
      tmr_tick  <= 1'b0;
      inst_tick <= 1'b0;
    end else begin
      tmr_tick  <= (tdiv_reg == TMR_DIV - 1);
      inst_tick <= (idiv_reg == INST_DIV - 1);
      tdiv_reg  <= (tdiv_reg == TMR_DIV - 1) ? 8'h00 : tdiv_reg + 8'h01;
      idiv_reg  <= (idiv_reg == INST_DIV - 1) ? 8'h00 : idiv_reg + 8'h01;
    end
  end

  // the timer advances on the instruction tick when that source is selected
  assign tick = inst_sel_reg ? inst_tick : tmr_tick;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchroniser: q1 feeds only q2; a change counts once q2 and q3 agree
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_q1     <= 1'b0;
      ext_q2     <= 1'b0;
      ext_q3     <= 1'b0;
      ext_stable <= 1'b0;
    end else begin
      ext_q1 <= ext_reset_trigger_in;
      ext_q2 <= ext_q1;
      ext_q3 <= ext_q2;
      if (ext_q2 == ext_q3)
        ext_stable <= ext_q3;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // tick-domain delay: two ticks on timer clock, one on instruction clock
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s1   <= 1'b0;
      ext_s2   <= 1'b0;
      on_s1    <= 1'b0;
      on_s2    <= 1'b0;
      ext_prev <= 1'b0;
    end else if (tick) begin
      ext_s1   <= ext_stable;
      ext_s2   <= ext_s1;
      on_s1    <= timer_on;
      on_s2    <= on_s1;
      // history keeps tracking in halt, so an edge made then is not replayed on resume
      ext_prev <= ext_eff;
    end
  end

  assign ext_eff = inst_sel_reg ? ext_s1 : ext_s2;
  assign on_eff  = inst_sel_reg ? on_s1 : on_s2;

  //////////////////////////////////////////////////////////////////////////////
  // mode decode and edge qualification
  assign grp      = mode_reg[4:3];
  assign lo       = mode_reg[2:0];
  assign ext_rise = !debug_halt && ext_eff && !ext_prev;
  assign ext_fall = !debug_halt && !ext_eff && ext_prev;
  assign is_match = (count_value == period_value);

  // start edge per lower code, shared by one-shot and monostable groups
  assign start_edge = ((lo == `HLT_LO_RISE) || (lo == `HLT_LO_RISE_RST) ||
                       (lo == `HLT_LO_RISE_LOWRST)) ? ext_rise :
                      ((lo == `HLT_LO_FALL) || (lo == `HLT_LO_FALL_RST) ||
                       (lo == `HLT_LO_FALL_HIGHRST)) ? ext_fall :
                      (lo == `HLT_LO_ANY) ? (ext_rise || ext_fall) : 1'b0;

  //////////////////////////////////////////////////////////////////////////////
  // counter next state, evaluated for the coming tick
  always @* begin
    count_next    = count_value;
    armed_next    = armed_reg;
    need_rst_next = need_rst_reg;
    hw_clear_on   = 1'b0;
    match_next    = 1'b0;
    case (grp)
      `HLT_GRP_FREE: begin
        // only the software gate lives here; other codes behave the same
        if (on_eff) begin
          match_next = is_match;
          count_next = is_match ? 8'h00 : count_value + 8'h01;
        end
      end
      `HLT_GRP_ONESHOT: begin
        if (!on_eff) begin
          armed_next = 1'b0;
        end else if (lo == `HLT_LO_SOFT) begin
          armed_next = 1'b1;
        end else if (!armed_reg) begin
          armed_next = start_edge;
        end
        if (on_eff && armed_reg) begin
          if (is_match) begin
            match_next  = 1'b1;
            count_next  = 8'h00;
            hw_clear_on = 1'b1;
            armed_next  = 1'b0;
          end else if ((lo == `HLT_LO_RISE_RST && ext_rise) ||
                       (lo == `HLT_LO_FALL_RST && ext_fall)) begin
            count_next = 8'h00;
          end else if ((lo == `HLT_LO_RISE_LOWRST && !debug_halt && !ext_eff) ||
                       (lo == `HLT_LO_FALL_HIGHRST && !debug_halt && ext_eff)) begin
            count_next = 8'h00;
          end else begin
            count_next = count_value + 8'h01;
          end
        end
      end
      `HLT_GRP_MONO: begin
        if ((lo == `HLT_LO_RISE) || (lo == `HLT_LO_FALL) || (lo == `HLT_LO_ANY)) begin
          if (!on_eff)
            armed_next = 1'b0;
          else if (!armed_reg)
            armed_next = start_edge;
          if (on_eff && armed_reg) begin
            if (is_match) begin
              match_next = 1'b1;
              count_next = 8'h00;
              armed_next = 1'b0;
            end else begin
              count_next = count_value + 8'h01;
            end
          end
        end else if ((lo == `HLT_LO_RISE_LOWRST) || (lo == `HLT_LO_FALL_HIGHRST)) begin
          // level start: code 110 starts high, resets low; 111 the reverse
          if (!on_eff || debug_halt) begin
            armed_next = 1'b0;
          end else if ((lo == `HLT_LO_RISE_LOWRST) != ext_eff) begin
            count_next    = 8'h00;
            armed_next    = 1'b0;
            need_rst_next = 1'b0;
          end else if (!armed_reg && !need_rst_reg) begin
            armed_next = 1'b1;
          end else if (armed_reg) begin
            if (is_match) begin
              match_next    = 1'b1;
              count_next    = 8'h00;
              armed_next    = 1'b0;
              need_rst_next = 1'b1;
            end else begin
              count_next = count_value + 8'h01;
            end
          end
        end
        // codes 000, 100 and 101 are reserved: the counter holds
      end
      default: begin
        count_next = count_value;
      end
    endcase
  end

  // counter and arming state move only on the selected tick
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_value  <= `HLT_RST_COUNT;
      armed_reg    <= 1'b0;
      need_rst_reg <= 1'b0;
      period_match <= 1'b0;
    end else begin
      period_match <= tick && match_next;
      if (tick) begin
        count_value  <= count_next;
        armed_reg    <= armed_next;
        need_rst_reg <= need_rst_next;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait states, pready comes from a flop raised after setup
  assign apb_setup = psel && !penable && !pready;
  assign apb_write = psel && penable && pready && pwrite;
  assign rd_hit    = addr_mapped(paddr);
  assign rd_word   = (paddr == `HLT_OFF_CTRL)   ? {23'h000000, inst_sel_reg, timer_on,
                                                   2'h0, mode_reg} :
                     (paddr == `HLT_OFF_PERIOD) ? {24'h000000, period_value} :
                     (paddr == `HLT_OFF_COUNT)  ? {24'h000000, count_value} :
                     (paddr == `HLT_OFF_STATUS) ? {29'h00000000, on_eff, ext_eff,
                                                   armed_reg} :
                     32'h00000000;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= apb_setup;
      pslverr <= apb_setup && !rd_hit;
      if (apb_setup)
        prdata <= pwrite ? 32'h00000000 : rd_word;
    end
  end

  // configuration registers; a software write to enable beats a hardware clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg     <= `HLT_RST_MODE;
      inst_sel_reg <= 1'b0;
      timer_on     <= 1'b0;
      period_value <= `HLT_RST_PERIOD;
    end else begin
      if (tick && hw_clear_on)
        timer_on <= 1'b0;
      if (apb_write && paddr == `HLT_OFF_CTRL) begin
        mode_reg     <= pwdata[`HLT_CTRL_MODE_HI:`HLT_CTRL_MODE_LO];
        timer_on     <= pwdata[`HLT_CTRL_ON];
        inst_sel_reg <= pwdata[`HLT_CTRL_INST];
      end
      if (apb_write && paddr == `HLT_OFF_PERIOD)
        period_value <= pwdata[7:0];
    end
  end

endmodule // hlt_timer

// file: testbench/hlt_timer_monitor.sv
`timescale 1ns/100ps
module hlt_timer_monitor (
  // apb side
  input wire        pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire [11:0] paddr,
  input wire [31:0] pwdata, prdata,
  // timer side
  input wire        ext_reset_trigger_in, debug_halt, period_match, timer_on,
  input wire [7:0]  count_value
);
  reg  [4:0] mode_q;
  reg        inst_q;
  reg  [4:0] off_cnt;
  wire       ctrl_wr = psel & penable & pready & pwrite & (paddr == 12'h000);
  // shadow of mode and tick select; off_cnt saturates so long idle spans stay cheap
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q  <= 5'h00;
      inst_q  <= 1'b0;
      off_cnt <= 5'h00;
    end else begin
      if (ctrl_wr) begin
        mode_q <= pwdata[4:0];
        inst_q <= pwdata[8];
      end
      off_cnt <= timer_on ? 5'h00 : ((off_cnt == 5'h1f) ? off_cnt : off_cnt + 5'h01);
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_apb_ready_next: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_count_step: assert property ($changed(count_value) |->
    count_value == $past(count_value) + 8'h01 || count_value == 8'h00)
    else $error("count jumped");
  a_hold_while_off: assert property (off_cnt >= 5'd20 |-> $stable(count_value))
    else $error("count moved while off");
  a_match_to_zero: assert property (period_match |-> count_value == 8'h00)
    else $error("match without zero");
  a_oneshot_clears_on: assert property (period_match && mode_q[4:3] == 2'b01
    && !$past(ctrl_wr) |-> !timer_on) else $error("one-shot kept enable");
  a_mono_keeps_on: assert property (period_match && mode_q[4:3] == 2'b10
    && $past(timer_on) && !$past(ctrl_wr) |-> timer_on) else $error("mono cleared enable");
  a_sync_two_ticks: assert property ($rose(timer_on) && !inst_q && mode_q == 5'h00
    |=> $stable(count_value) [*7]) else $error("enable acted too early");
  a_inst_next_period: assert property ($rose(timer_on) && inst_q && mode_q == 5'h00
    |-> ##[1:16] $changed(count_value)) else $error("enable acted too late");
  a_reserved_holds: assert property (mode_q[4:3] == 2'b11
    && $past(mode_q[4:3]) == 2'b11 |-> $stable(count_value)) else $error("reserved counted");
endmodule // hlt_timer_monitor

bind hlt_timer hlt_timer_monitor hlt_timer_monitor_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .ext_reset_trigger_in(ext_reset_trigger_in),
  .debug_halt(debug_halt), .period_match(period_match), .timer_on(timer_on),
  .count_value(count_value));

// file: testbench/hlt_trig_src.sv
`timescale 1ns/100ps
module hlt_trig_src #(
  parameter GAP = 24
) (
  input  wire  pclk,
  output logic ext_reset_trigger_in
);
  int cyc  = 0;
  int mark = -100;
  initial ext_reset_trigger_in = 1'b0;
  // free cycle count, used to space level changes
  always @(posedge pclk) cyc <= cyc + 1;
  // six ticks between edges also gives every level at least three ticks
  task automatic move(input logic v);
    while (cyc - mark < GAP) @(posedge pclk);
    ext_reset_trigger_in <= v;
    mark = cyc;
  endtask
endmodule // hlt_trig_src

// file: testbench/test_hlt_timer.sv
`timescale 1ns/100ps
module test_hlt_timer;
  logic        pclk, presetn, psel, penable, pwrite;
  logic        debug_halt, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, q;
  logic [7:0]  lfsr = 8'h1d, c;
  wire  [31:0] prdata;
  wire  [7:0]  count_value;
  wire         pready, pslverr, period_match, timer_on, ext_reset_trigger_in;
  int          fails = 0, checks = 0, m, per, n;
  logic [4:0]  codes [15] = '{5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h10,
                              5'h11, 5'h12, 5'h13, 5'h14, 5'h16, 5'h17, 5'h18};
  logic [11:0] addrs [5]  = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010};
  hlt_timer hlt_timer_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_reset_trigger_in(ext_reset_trigger_in), .debug_halt(debug_halt),
    .count_value(count_value), .period_match(period_match), .timer_on(timer_on));
  hlt_trig_src hlt_trig_src_i (.pclk(pclk), .ext_reset_trigger_in(ext_reset_trigger_in));
  // 40 MHz clock
  initial pclk = 1'b0;
  always #12.5 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask
  // one apb transfer; first edge wait keeps back-to-back calls from double-driving psel
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fails++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task rst();
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  task wait_sig(input int which);
    c = count_value;
    n = 0;
    while (((which == 0) ? count_value === c : period_match !== 1'b1) && n < 400) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 400) fails++;
  endtask
  task conclude();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // watchdog, well past the few thousand cycles the sequence needs
  initial begin
    repeat (40000) @(posedge pclk);
    fails++;
    conclude();
  end
  ////////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    psel       <= 1'b0;
    penable    <= 1'b0;
    pwrite     <= 1'b0;
    paddr      <= 12'h000;
    pwdata     <= 32'h0;
    debug_halt <= 1'b0;
    rst();
    foreach (addrs[i]) begin
      apb(1'b0, addrs[i], 32'h0);
      chk(q, (i == 1) ? 32'h000000ff : 32'h0, "reset value");
      chk(e, (i == 4), "slave error");
    end
    apb(1'b1, 12'h008, 32'h55);
    chk(e, 1'b0, "count write error");
    apb(1'b0, 12'h008, 32'h0);
    chk(q, 32'h0, "count read only");
    // software gate against an integer model, timer tick then instruction tick
    for (int k = 0; k < 2; k++) begin
      rst();
      lfsr = lfsr_next(lfsr);
      per = 3 + lfsr[2:0];
      apb(1'b1, 12'h004, per);
      apb(1'b1, 12'h000, 32'h80 | (k << 8));
      m = 0;
      for (int i = 0; i < 2 * (per + 1); i++) begin
        wait_sig(0);
        m = (m == per) ? 0 : m + 1;
        chk(count_value, m, "free count");
      end
      apb(1'b1, 12'h000, k << 8);
      repeat (20) @(posedge pclk);
      c = count_value;
      repeat (40) @(posedge pclk);
      chk(count_value, c, "hold when off");
    end
    // software one-shot stops at zero and clears enable
    rst();
    apb(1'b1, 12'h004, 32'h2);
    apb(1'b1, 12'h000, 32'h188);
    wait_sig(1);
    chk(timer_on, 1'b0, "one-shot enable");
    repeat (40) @(posedge pclk);
    chk(count_value, 8'h00, "one-shot stop");
    // rising start needs a fresh edge after re-enable; debug halt masks edges
    rst();
    hlt_trig_src_i.move(1'b0);
    debug_halt <= 1'b1;
    apb(1'b1, 12'h004, 32'hc8);
    apb(1'b1, 12'h000, 32'h89);
    hlt_trig_src_i.move(1'b1);
    repeat (40) @(posedge pclk);
    chk(count_value, 8'h00, "edge seen in halt");
    debug_halt <= 1'b0;
    // the edge made during halt must not start the timer once halt ends
    repeat (40) @(posedge pclk);
    chk(count_value, 8'h00, "halt edge replayed");
    hlt_trig_src_i.move(1'b0);
    hlt_trig_src_i.move(1'b1);
    repeat (40) @(posedge pclk);
    chk(count_value !== 8'h00, 1'b1, "edge start");
    apb(1'b1, 12'h000, 32'h09);
    // enable is sampled on ticks only, so the off span must outlast the sync delay
    repeat (20) @(posedge pclk);
    apb(1'b1, 12'h000, 32'h89);
    c = count_value;
    repeat (40) @(posedge pclk);
    chk(count_value, c, "resumed without edge");
    hlt_trig_src_i.move(1'b0);
    hlt_trig_src_i.move(1'b1);
    repeat (40) @(posedge pclk);
    chk(count_value !== c, 1'b1, "fresh edge resume");
    // monostable keeps enable at the match and does not rearm by itself
    rst();
    hlt_trig_src_i.move(1'b0);
    apb(1'b1, 12'h004, 32'h3);
    apb(1'b1, 12'h000, 32'h91);
    hlt_trig_src_i.move(1'b1);
    wait_sig(1);
    chk(timer_on, 1'b1, "mono enable");
    repeat (40) @(posedge pclk);
    chk(count_value, 8'h00, "mono stop");
    // every trigger code: idle level first, then the start transition
    foreach (codes[i]) begin
      rst();
      c = {5'h0, codes[i][2:0]};
      hlt_trig_src_i.move(c == 2 || c == 5 || c == 7);
      apb(1'b1, 12'h004, 32'hc8);
      apb(1'b1, 12'h000, 32'h80 | codes[i]);
      repeat (40) @(posedge pclk);
      chk(count_value, 8'h00, "started early");
      hlt_trig_src_i.move(!(c == 2 || c == 5 || c == 7));
      repeat (40) @(posedge pclk);
      chk(count_value !== 8'h00, (codes[i][4:3] == 2'b01) ||
        (codes[i][4:3] == 2'b10 && c != 0 && c != 4 && c != 5), "start by code");
    end
    conclude();
  end
endmodule // test_hlt_timer
